// file: cas_pkg.sv
// Constants and types of the ALU and core status register bank.
// Assumes a Wishbone slave with 8-bit byte addresses and 8-bit data.
package cas_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] ALU_STA_IDX = 8'h04;
    localparam logic [7:0] CPU_STA_IDX = 8'h06;
    localparam logic [7:0] PTR0_IDX = 8'h08;
    localparam logic [7:0] PTR1_IDX = 8'h09;
    localparam logic [7:0] RESULT_IDX = 8'h0A;
    localparam logic [7:0] ALU_STA_ADDR = {ALU_STA_IDX[5:0], 2'b00};
    localparam logic [7:0] CPU_STA_ADDR = {CPU_STA_IDX[5:0], 2'b00};
    localparam logic [7:0] PTR0_ADDR = {PTR0_IDX[5:0], 2'b00};
    localparam logic [7:0] PTR1_ADDR = {PTR1_IDX[5:0], 2'b00};
    localparam logic [7:0] RESULT_ADDR = {RESULT_IDX[5:0], 2'b00};

    // ALU status fields
    localparam int ALU_C_BIT = 0;
    localparam int ALU_DC_BIT = 1;
    localparam int ALU_Z_BIT = 2;
    localparam int ALU_OV_BIT = 3;
    localparam int ALU_FS0_LSB = 4;
    localparam logic [7:0] ALU_STA_RST = 8'hF0;

    // Core status fields
    localparam int CPU_BOR_BIT = 0;
    localparam int CPU_POR_BIT = 1;
    localparam int CPU_PD_BIT = 2;
    localparam int CPU_TO_BIT = 3;
    localparam int CPU_GLOBAL_IRQ_MASK_BIT = 4;
    localparam int CPU_STACK_ROOM_FLAG_BIT = 5;
    localparam logic [7:0] CPU_STA_RST = 8'h3D;
    localparam logic [7:0] CPU_WR_MASK = 8'h13;
    localparam logic [7:0] CPU_IMPL_MASK = 8'h3F;

    // Pointer update modes; 1x holds the pointer
    localparam logic [1:0] PTR_POST_DEC = 2'h0;
    localparam logic [1:0] PTR_POST_INC = 2'h1;

    localparam logic [3:0] STACK_TOP = 4'hF;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_MOVE = 4'h1,
        OP_ADD = 4'h2,
        OP_SUB = 4'h3,
        OP_AND = 4'h4,
        OP_IOR = 4'h5,
        OP_XOR = 4'h6,
        OP_CLEAR = 4'h7,
        OP_RRC = 4'h8,
        OP_RLC = 4'h9
    } cas_op_t;

endpackage

// file: cas_alu.sv
// Result and condition flags of one instruction, purely combinational.
// Assumes the caller picks operands and latches the outputs.
`timescale 1ns/10ps
module cas_alu (
    input wire cas_pkg::cas_op_t op_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] opnd_i,
    input wire logic [7:0] single_i,
    input wire logic carry_i,
    output logic [7:0] res_o,
    output logic [3:0] flags_o,
    output logic [3:0] affect_o
);
    import cas_pkg::*;

    logic [8:0] sum9;
    logic [4:0] nib5;
    logic c;
    logic dc;
    logic ov;

    always_comb begin
        sum9 = 9'h000;
        nib5 = 5'h00;
        res_o = acc_i;
        c = carry_i;
        dc = 1'b0;
        ov = 1'b0;
        affect_o = 4'h0;
        case (op_i)
            OP_ADD: begin
                sum9 = {1'b0, acc_i} + {1'b0, opnd_i};
                nib5 = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]};
                res_o = sum9[7:0];
                c = sum9[8];
                dc = nib5[4];
                ov = (acc_i[7] == opnd_i[7]) && (sum9[7] != acc_i[7]);
                affect_o = 4'hF;
            end
            OP_SUB: begin
                // Operand minus accumulator via two's complement add
                sum9 = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
                nib5 = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
                res_o = sum9[7:0];
                c = sum9[8];
                dc = nib5[4];
                ov = (opnd_i[7] != acc_i[7]) && (sum9[7] != opnd_i[7]);
                affect_o = 4'hF;
            end
            OP_AND: begin
                res_o = acc_i & opnd_i;
                affect_o = 4'h4;
            end
            OP_IOR: begin
                res_o = acc_i | opnd_i;
                affect_o = 4'h4;
            end
            OP_XOR: begin
                res_o = acc_i ^ opnd_i;
                affect_o = 4'h4;
            end
            OP_CLEAR: begin
                res_o = 8'h00;
                affect_o = 4'h4;
            end
            OP_RRC: begin
                res_o = {carry_i, single_i[7:1]};
                c = single_i[0];
                affect_o = 4'h1;
            end
            OP_RLC: begin
                res_o = {single_i[6:0], carry_i};
                c = single_i[7];
                affect_o = 4'h1;
            end
            OP_MOVE: begin
                res_o = single_i;
            end
            default: begin
                res_o = acc_i;
            end
        endcase
        flags_o = {ov, (res_o == 8'h00), dc, c};
    end
endmodule // cas_alu

// file: cas_ptr.sv
// Post-access update of one indirect pointer.
// Assumes the caller applies the result only on an indirect access.
`timescale 1ns/10ps
module cas_ptr (
    input wire logic [1:0] mode_i,
    input wire logic [7:0] ptr_i,
    output logic [7:0] next_o
);
    import cas_pkg::*;

    always_comb begin
        case (mode_i)
            PTR_POST_DEC: next_o = ptr_i - 8'h01;
            PTR_POST_INC: next_o = ptr_i + 8'h01;
            default: next_o = ptr_i;
        endcase
    end
endmodule // cas_ptr

// file: cas_regs.sv
// ALU flag and pointer mode register, core status and reset cause register.
// Assumes Wishbone classic master, same-clock event inputs, rst_i = power-on.
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
module cas_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [0:0] wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic op_valid_i,
    input wire cas_pkg::cas_op_t op_code_i,
    input wire logic op_src_file_i,
    input wire logic op_dest_status_i,
    input wire logic [7:0] working_accumulator_i,
    input wire logic [7:0] file_operand_i,
    input wire logic [7:0] imm_operand_i,
    output logic [7:0] result_o,
    output logic result_valid_o,
    input wire logic [1:0] ind_access_i,
    output logic [7:0] first_indirect_pointer_o,
    output logic [7:0] second_indirect_pointer_o,
    output logic [7:0] alu_flags_and_pointer_modes_o,
    output logic [7:0] core_status_and_reset_cause_o,
    input wire logic stack_push_i,
    input wire logic stack_pop_i,
    input wire logic watchdog_kick_instr_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_timeout_i,
    input wire logic external_reset_pin_evt_i,
    input wire logic brownout_reset_i,
    input wire logic brownout_detect_fuse_i,
    input wire logic irq_request_i,
    output logic irq_take_o
);
    import cas_pkg::*;

    typedef struct packed {
        logic [7:0] alu;
        logic [7:0] cpu;
        logic [3:0] sp;
        logic lock;
        logic [1:0][7:0] ptr;
        logic [7:0] result;
        logic res_valid;
        logic ack;
        logic [7:0] rdat;
    } cas_state_t;

    localparam cas_state_t RESET_STATE = '{
        alu: ALU_STA_RST, cpu: CPU_STA_RST, sp: 4'h0, lock: 1'b0,
        ptr: '0, result: 8'h00, res_valid: 1'b0, ack: 1'b0, rdat: 8'h00};

    cas_state_t s;
    cas_state_t next_s;

    logic [7:0] opnd;
    logic [7:0] single;
    logic [7:0] alu_res;
    logic [3:0] alu_flags;
    logic [3:0] alu_aff;
    logic [1:0][7:0] ptr_upd;
    logic req;
    logic wr;
    logic dev_reset;
    logic [7:0] fl;

    // Second operand and single operand source
    assign opnd = op_src_file_i ? file_operand_i : imm_operand_i;
    assign single = op_src_file_i ? file_operand_i : working_accumulator_i;

    cas_alu u_alu (
        .op_i(op_code_i),
        .acc_i(working_accumulator_i),
        .opnd_i(opnd),
        .single_i(single),
        .carry_i(s.alu[ALU_C_BIT]),
        .res_o(alu_res),
        .flags_o(alu_flags),
        .affect_o(alu_aff)
    );

    // Pointer 0 uses bits 5-4, pointer 1 bits 7-6
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            cas_ptr u_ptr (
                .mode_i(s.alu[ALU_FS0_LSB + 2 * gi +: 2]),
                .ptr_i(s.ptr[gi]),
                .next_o(ptr_upd[gi])
            );
        end
    endgenerate

    assign req = wb_cyc_i & wb_stb_i & ~s.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign dev_reset = external_reset_pin_evt_i | watchdog_timeout_i | brownout_reset_i;

    always_comb begin
        next_s = s;
        fl = 8'h00;
        if (ce_i) begin
            next_s.ack = req;
            if (req) begin
                case (wb_adr_i)
                    ALU_STA_ADDR: next_s.rdat = s.alu;
                    CPU_STA_ADDR: next_s.rdat = s.cpu & CPU_IMPL_MASK;
                    PTR0_ADDR: next_s.rdat = s.ptr[0];
                    PTR1_ADDR: next_s.rdat = s.ptr[1];
                    RESULT_ADDR: next_s.rdat = s.result;
                    default: next_s.rdat = 8'h00;
                endcase
            end
            if (wr && wb_adr_i == ALU_STA_ADDR) begin
                next_s.alu = wb_dat_i;
            end
            if (wr && wb_adr_i == CPU_STA_ADDR) begin
                // Only mask and reset-cause bits take software data
                next_s.cpu = (s.cpu & ~CPU_WR_MASK) | (wb_dat_i & CPU_WR_MASK);
            end
            if (wr && wb_adr_i == PTR0_ADDR) begin
                next_s.ptr[0] = wb_dat_i;
            end
            if (wr && wb_adr_i == PTR1_ADDR) begin
                next_s.ptr[1] = wb_dat_i;
            end
            // Instruction result and flags in one cycle
            next_s.res_valid = op_valid_i;
            if (op_valid_i) begin
                next_s.result = alu_res;
                fl = next_s.alu;
                if (op_dest_status_i) begin
                    fl[7:4] = alu_res[7:4];
                    if (alu_aff == 4'h0) begin
                        fl[3:0] = alu_res[3:0];
                    end else begin
                        fl[3:0] = s.alu[3:0];
                    end
                end
                fl[3:0] = (fl[3:0] & ~alu_aff) | (alu_flags & alu_aff);
                next_s.alu = fl;
            end
            for (int i = 0; i < 2; i++) begin
                if (ind_access_i[i]) begin
                    next_s.ptr[i] = ptr_upd[i];
                end
            end
            // Stack pointer and room flag
            if (stack_push_i && !stack_pop_i) begin
                next_s.sp = s.sp + 4'h1;
                if (s.sp == STACK_TOP) begin
                    next_s.lock = 1'b1;
                end
            end else if (stack_pop_i && !stack_push_i) begin
                next_s.sp = s.sp - 4'h1;
            end
            // Power state events
            if (watchdog_kick_instr_i) begin
                next_s.cpu[CPU_TO_BIT] = 1'b1;
                next_s.cpu[CPU_PD_BIT] = 1'b1;
            end
            if (sleep_instr_i) begin
                next_s.cpu[CPU_TO_BIT] = 1'b1;
                next_s.cpu[CPU_PD_BIT] = 1'b0;
            end
            if (watchdog_timeout_i) begin
                next_s.cpu[CPU_TO_BIT] = 1'b0;
            end
            // Device resets other than power-on; pin reset keeps TO and PD
            if (dev_reset) begin
                next_s.sp = 4'h0;
                next_s.lock = 1'b0;
                next_s.cpu[CPU_GLOBAL_IRQ_MASK_BIT] = 1'b1;
                next_s.alu[7:4] = ALU_STA_RST[7:4];
                next_s.res_valid = 1'b0;
            end
            if (brownout_reset_i) begin
                next_s.cpu[CPU_TO_BIT] = 1'b1;
                next_s.cpu[CPU_PD_BIT] = 1'b1;
                if (brownout_detect_fuse_i) begin
                    next_s.cpu[CPU_BOR_BIT] = 1'b0;
                end
            end
            next_s.cpu[CPU_STACK_ROOM_FLAG_BIT] = !next_s.lock && (next_s.sp != STACK_TOP);
        end
    end

    // Power-on reset clears its cause flag via the reset value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign result_o = s.result;
    assign result_valid_o = s.res_valid;
    assign first_indirect_pointer_o = s.ptr[0];
    assign second_indirect_pointer_o = s.ptr[1];
    assign alu_flags_and_pointer_modes_o = s.alu;
    assign core_status_and_reset_cause_o = s.cpu & CPU_IMPL_MASK;
    assign irq_take_o = irq_request_i & ~s.cpu[CPU_GLOBAL_IRQ_MASK_BIT];

    // Checks
    logic signed [9:0] add_wide;
    logic [4:0] nib_sum;
    logic quiet;
    assign add_wide = $signed({{2{working_accumulator_i[7]}}, working_accumulator_i})
        + $signed({{2{opnd[7]}}, opnd});
    assign nib_sum = {1'b0, working_accumulator_i[3:0]} + {1'b0, opnd[3:0]};
    assign quiet = !dev_reset && !wr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_flag_write_blocked: assert property (
        ce_i && op_valid_i && op_dest_status_i && alu_aff != 4'h0 && quiet
        |=> (s.alu[3:0] & ~$past(alu_aff)) == ($past(s.alu[3:0]) & ~$past(alu_aff))
            && s.alu[7:4] == $past(alu_res[7:4]))
        else $error("status write not blocked");
    a_sub_borrow: assert property (
        ce_i && op_valid_i && op_code_i == OP_SUB
        |=> s.alu[ALU_C_BIT] == ($past(opnd) >= $past(working_accumulator_i)))
        else $error("borrow polarity wrong");
    a_signed_excess: assert property (
        ce_i && op_valid_i && op_code_i == OP_ADD
        |=> s.alu[ALU_OV_BIT] ==
            ($past(add_wide) > $signed(10'h07F) || $past(add_wide) < $signed(10'h380)))
        else $error("signed excess flag wrong");
    a_second_ptr_inc: assert property (
        ce_i && ind_access_i[1] && s.alu[7:6] == PTR_POST_INC
        |=> s.ptr[1] == $past(s.ptr[1]) + 8'h01)
        else $error("second pointer not incremented");
    a_first_ptr_hold: assert property (
        ce_i && ind_access_i[0] && s.alu[5] && !(wr && wb_adr_i == PTR0_ADDR)
        |=> $stable(s.ptr[0]))
        else $error("first pointer moved in hold mode");
    a_first_ptr_dec: assert property (
        ce_i && ind_access_i[0] && s.alu[5:4] == PTR_POST_DEC
        |=> s.ptr[0] == $past(s.ptr[0]) - 8'h01)
        else $error("first pointer not decremented");
    a_second_ptr_dec: assert property (
        ce_i && ind_access_i[1] && s.alu[7:6] == PTR_POST_DEC
        |=> s.ptr[1] == $past(s.ptr[1]) - 8'h01)
        else $error("second pointer not decremented");
    a_zero_flag: assert property (
        ce_i && op_valid_i && alu_aff[ALU_Z_BIT]
        |=> s.alu[ALU_Z_BIT] == (s.result == 8'h00))
        else $error("zero flag wrong");
    a_nibble_carry: assert property (
        ce_i && op_valid_i && op_code_i == OP_ADD
        |=> s.alu[ALU_DC_BIT] == $past(nib_sum[4]))
        else $error("nibble carry wrong");
    a_rotate_carry: assert property (
        ce_i && op_valid_i && op_code_i == OP_RLC
        |=> s.alu[ALU_C_BIT] == $past(single[7]))
        else $error("rotate carry wrong");
    a_status_ro_bits: assert property (
        ce_i && wr && wb_adr_i == CPU_STA_ADDR && !dev_reset && !watchdog_kick_instr_i
        && !sleep_instr_i && !stack_push_i && !stack_pop_i
        |=> $stable(s.cpu[CPU_STACK_ROOM_FLAG_BIT])
            && $stable(s.cpu[CPU_TO_BIT:CPU_PD_BIT]))
        else $error("read-only status bit written");
    a_stack_lock: assert property (
        s.lock || s.sp == STACK_TOP |-> !s.cpu[CPU_STACK_ROOM_FLAG_BIT])
        else $error("stack room flag set while full");
    a_irq_gate: assert property (
        s.cpu[CPU_GLOBAL_IRQ_MASK_BIT] |-> !irq_take_o)
        else $error("interrupt passed global mask");
    a_wdt_expiry: assert property (
        ce_i && watchdog_timeout_i && !brownout_reset_i |=> !s.cpu[CPU_TO_BIT])
        else $error("time-out did not clear flag");
    a_sleep_flags: assert property (
        ce_i && sleep_instr_i && !dev_reset
        |=> !s.cpu[CPU_PD_BIT] && s.cpu[CPU_TO_BIT])
        else $error("sleep flags wrong");
    a_por_cleared: assert property (
        $past(rst_i) |-> !s.cpu[CPU_POR_BIT])
        else $error("power-on flag not cleared");
    a_brownout_flag: assert property (
        ce_i && brownout_reset_i && brownout_detect_fuse_i |=> !s.cpu[CPU_BOR_BIT])
        else $error("brown-out flag not cleared");
    a_pin_reset_keep: assert property (
        ce_i && external_reset_pin_evt_i && !watchdog_timeout_i && !brownout_reset_i
        && !watchdog_kick_instr_i && !sleep_instr_i
        |=> $stable(s.cpu[CPU_TO_BIT:CPU_PD_BIT]))
        else $error("pin reset changed power flags");
    a_reset_stack: assert property (
        ce_i && dev_reset |=> s.sp == 4'h0 && s.cpu[CPU_STACK_ROOM_FLAG_BIT])
        else $error("device reset left stack state");
    a_result_same: assert property (
        ce_i && op_valid_i && !dev_reset |=> result_valid_o && result_o == $past(alu_res))
        else $error("result late");

    // Bus handshake, clock enable and reset mask
    a_ack_pulse: assert property (
        ce_i && s.ack |=> !s.ack)
        else $error("ack held past one cycle");
    a_ce_freeze: assert property (
        !ce_i |=> $stable(s))
        else $error("state moved while clock enable low");
    a_reset_mask: assert property (
        ce_i && dev_reset |=> s.cpu[CPU_GLOBAL_IRQ_MASK_BIT])
        else $error("device reset left interrupts enabled");

    // Main scenarios reached
    c_sub_to_status: cover property (
        ce_i && op_valid_i && op_code_i == OP_SUB && op_dest_status_i);
    c_stack_wrap: cover property (ce_i && stack_push_i && s.sp == STACK_TOP);
    c_bus_write: cover property (wr && wb_adr_i == CPU_STA_ADDR ##1 s.ack);
    c_pin_unlock: cover property (ce_i && external_reset_pin_evt_i && s.lock);
    c_move_to_status: cover property (
        ce_i && op_valid_i && op_code_i == OP_MOVE && op_dest_status_i);
endmodule // cas_regs

// file: cas_regs_bench.sv
// Self-checking bench for the ALU flag and core status register bank.
// Assumes cas_regs answers each Wishbone request one cycle after taking it.
`timescale 1ns/10ps
module cas_regs_bench;
    import cas_pkg::*;
    logic clk = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b1, irq = 1'b0, fuse = 1'b1;
    logic opv = 1'b0, srcf = 1'b0, dst = 1'b0, ce = 1'b1;
    logic [7:0] adr = 8'h00, wdat = 8'h00, acc = 8'h00, fop = 8'h00, imm = 8'h00;
    logic [8:0] evt = 9'h000;
    cas_op_t opc = OP_NONE;
    logic [7:0] rdat, res, ptr0, ptr1, alu, core;
    logic ack, resv, take;
    int fails = 0, cmp_count = 0, cyc_cnt = 0;

    always #50 clk = ~clk;

    cas_regs DUT (.clk_i(clk), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .op_valid_i(opv), .op_code_i(opc), .op_src_file_i(srcf),
        .op_dest_status_i(dst), .working_accumulator_i(acc), .file_operand_i(fop),
        .imm_operand_i(imm), .result_o(res), .result_valid_o(resv), .ind_access_i(evt[8:7]),
        .first_indirect_pointer_o(ptr0), .second_indirect_pointer_o(ptr1),
        .alu_flags_and_pointer_modes_o(alu), .core_status_and_reset_cause_o(core),
        .stack_push_i(evt[0]), .stack_pop_i(evt[1]), .watchdog_kick_instr_i(evt[2]),
        .sleep_instr_i(evt[3]), .watchdog_timeout_i(evt[4]), .external_reset_pin_evt_i(evt[5]),
        .brownout_reset_i(evt[6]), .brownout_detect_fuse_i(fuse), .irq_request_i(irq),
        .irq_take_o(take));

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            fails++;
            wrap_up;
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic cycle held until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
        input logic s, output logic [7:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, 1'b1, q);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, 1'b1, q);
        check(what, exp, q);
    endtask

    // The unselected operand source gets the inverse, so a wrong pick shows
    task automatic op(input cas_op_t c, input logic f, input logic d, input logic [7:0] a,
        input logic [7:0] o, input logic [7:0] er, input logic [7:0] ea);
        opv <= 1'b1;
        opc <= c;
        srcf <= f;
        dst <= d;
        acc <= a;
        fop <= f ? o : ~o;
        imm <= f ? ~o : o;
        @(posedge clk);
        opv <= 1'b0;
        @(posedge clk);
        check("result", er, res);
        check("result valid", 8'h01, {7'h00, resv});
        check("alu status", ea, alu);
    endtask

    task automatic pulse(input logic [8:0] m, input logic [7:0] ec);
        evt <= m;
        @(posedge clk);
        evt <= 9'h000;
        @(posedge clk);
        check("core status", ec, core);
    endtask

    task automatic t_reset;
        rd("alu reg", ALU_STA_ADDR, 8'hF0);
        rd("core reg", CPU_STA_ADDR, 8'h3D);
        rd("unmapped", 8'h3C, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_arith;
        op(OP_ADD, 1'b0, 1'b0, 8'h7F, 8'h01, 8'h80, 8'hFA);
        op(OP_ADD, 1'b0, 1'b0, 8'hFF, 8'h01, 8'h00, 8'hF7);
        op(OP_ADD, 1'b1, 1'b0, 8'h08, 8'h08, 8'h10, 8'hF2);
        op(OP_SUB, 1'b0, 1'b0, 8'h01, 8'h80, 8'h7F, 8'hF9);
        op(OP_SUB, 1'b1, 1'b0, 8'h03, 8'h05, 8'h02, 8'hF3);
        op(OP_SUB, 1'b0, 1'b0, 8'h05, 8'h03, 8'hFE, 8'hF0);
        op(OP_RLC, 1'b0, 1'b0, 8'h81, 8'h00, 8'h02, 8'hF1);
        op(OP_RRC, 1'b0, 1'b0, 8'h02, 8'h00, 8'h81, 8'hF0);
        op(OP_RRC, 1'b1, 1'b0, 8'hFF, 8'h01, 8'h00, 8'hF1);
        op(OP_CLEAR, 1'b1, 1'b1, 8'h00, 8'h5A, 8'h00, 8'h05);
        op(OP_IOR, 1'b0, 1'b0, 8'h30, 8'h0C, 8'h3C, 8'h01);
        op(OP_AND, 1'b1, 1'b0, 8'hF0, 8'h0F, 8'h00, 8'h05);
        op(OP_XOR, 1'b0, 1'b0, 8'hFF, 8'h0F, 8'hF0, 8'h01);
        op(OP_MOVE, 1'b1, 1'b1, 8'h00, 8'hA6, 8'hA6, 8'hA6);
        $display("test arithmetic done");
    endtask

    task automatic t_ptr;
        rd("result reg", RESULT_ADDR, 8'hA6);
        wr(ALU_STA_ADDR, 8'h10);
        wr(PTR0_ADDR, 8'h10);
        wr(PTR1_ADDR, 8'h10);
        pulse(9'h180, 8'h3D);
        check("first pointer", 8'h11, ptr0);
        check("second pointer", 8'h0F, ptr1);
        wr(ALU_STA_ADDR, 8'hD0);
        pulse(9'h180, 8'h3D);
        check("first pointer", 8'h12, ptr0);
        check("second pointer", 8'h0F, ptr1);
        wr(ALU_STA_ADDR, 8'h40);
        pulse(9'h180, 8'h3D);
        check("first pointer", 8'h11, ptr0);
        check("second pointer", 8'h10, ptr1);
        wr(ALU_STA_ADDR, 8'hE0);
        pulse(9'h180, 8'h3D);
        check("first pointer", 8'h11, ptr0);
        check("second pointer", 8'h10, ptr1);
        rd("alu reg", ALU_STA_ADDR, 8'hE0);
        rd("first pointer reg", PTR0_ADDR, 8'h11);
        rd("second pointer reg", PTR1_ADDR, 8'h10);
        $display("test pointers done");
    endtask

    task automatic t_core;
        logic [7:0] q;
        irq <= 1'b1;
        bus(1'b1, CPU_STA_ADDR, 8'h00, 1'b0, q);
        rd("core reg", CPU_STA_ADDR, 8'h3D);
        check("irq take", 8'h00, {7'h00, take});
        wr(CPU_STA_ADDR, 8'h00);
        check("core status", 8'h2C, core);
        check("irq take", 8'h01, {7'h00, take});
        wr(CPU_STA_ADDR, 8'hFF);
        check("core status", 8'h3F, core);
        check("irq take", 8'h00, {7'h00, take});
        $display("test core status done");
    endtask

    task automatic t_wdt;
        // Frozen by clock enable: time-out must not land
        ce <= 1'b0;
        pulse(9'h010, 8'h3F);
        ce <= 1'b1;
        pulse(9'h010, 8'h37);
        pulse(9'h008, 8'h3B);
        pulse(9'h004, 8'h3F);
        $display("test watchdog done");
    endtask

    task automatic t_stack;
        pulse(9'h008, 8'h3B);
        repeat (14) pulse(9'h001, 8'h3B);
        pulse(9'h001, 8'h1B);
        pulse(9'h002, 8'h3B);
        pulse(9'h001, 8'h1B);
        pulse(9'h001, 8'h1B);
        pulse(9'h002, 8'h1B);
        pulse(9'h020, 8'h3B);
        pulse(9'h002, 8'h1B);
        pulse(9'h040, 8'h3E);
        wr(CPU_STA_ADDR, 8'h03);
        fuse <= 1'b0;
        pulse(9'h040, 8'h3F);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        check("core status", 8'h3D, core);
        $display("test stack and resets done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_i <= 1'b0;
        @(posedge clk);
        t_reset;
        t_arith;
        t_ptr;
        t_core;
        t_wdt;
        t_stack;
        wrap_up;
    end
endmodule // cas_regs_bench
